// >>> src/tcc_pkg.sv
`default_nettype none
package tcc_pkg;

  // register pointers
  localparam logic [7:0] PTR_RESET   = 8'h00;
  localparam logic [7:0] PTR_CFG_RD  = 8'h03;
  localparam logic [7:0] PTR_RATE_RD = 8'h04;
  localparam logic [7:0] PTR_CFG_WR  = 8'h09;
  localparam logic [7:0] PTR_RATE_WR = 8'h0a;
  localparam logic [7:0] PTR_ONESHOT = 8'h0f;
  localparam logic [7:0] PTR_CHEN    = 8'h16;
  localparam logic [7:0] PTR_CONSEC  = 8'h22;

  // configuration fields
  localparam int CFG_MASK_BIT   = 7;
  localparam int CFG_SD_BIT     = 6;
  localparam int CFG_PINSEL_BIT = 5;
  localparam int CFG_RANGE_BIT  = 2;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // rate, channel enable and consecutive count
  localparam logic [7:0] RATE_RESET   = 8'h08;
  localparam logic [7:0] RATE_MAX     = 8'h09;
  localparam int         CHEN_LOC_BIT = 0;
  localparam int         CHEN_REM_BIT = 1;
  localparam logic [1:0] CHEN_RESET   = 2'h3;
  localparam logic [2:0] CONSEC_RESET = 3'h0;

  // limit index: local high, local low, remote high, remote low
  localparam int LIM_LH = 0;
  localparam int LIM_RH = 2;

  // timing
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned PERIOD_MAX_S   = 16;
  localparam int unsigned PERIOD_MAX_CYC = PERIOD_MAX_S * CLK_HZ;
  localparam int          TMR_W          = 28;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_WAIT  = 2'b10
  } tcc_state_t;

endpackage
`default_nettype wire

// >>> src/tcc_conv_ctrl.sv
//////////////////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////////////////
`default_nettype none
module tcc_conv_ctrl
  import tcc_pkg::*;
#(
  parameter int unsigned PERIOD_CYC = PERIOD_MAX_CYC
) (
  // clock, reset, enable
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       ce,
  // byte port from the two-wire engine
  input  wire logic       ptr_wr,
  input  wire logic       data_wr,
  input  wire logic [7:0] wr_byte,
  input  wire logic       rd_strobe,
  output var  logic [7:0] rd_data_r,
  // converter front end
  output var  logic       conv_start_r,
  output var  logic       conv_chan_r,
  input  wire logic       conv_done,
  input  wire logic       res_high,
  input  wire logic       res_low,
  // status side
  input  wire logic       open_fault,
  input  wire logic       alert_ack,
  output var  logic [3:0] qual_r,
  output var  logic       alert_latch_r,
  output var  logic       busy_r,
  output var  logic       range_ext_r,
  // open-drain pin
  output var  logic       alert_pin_o_r,
  output var  logic       alert_pin_oe_r
);

  logic [7:0]       ptr_r;
  logic             mask_r;
  logic             sd_r;
  logic             pinsel_r;
  logic [7:0]       rate_r;
  logic [1:0]       chen_r;
  logic [2:0]       consec_r;
  logic             oneshot_r;
  tcc_state_t       state_r;
  logic [1:0]       pend_r;
  logic [TMR_W-1:0] tmr_r;
  logic [2:0]       cnt_r [4];
  logic [7:0]       cfg_view;
  logic [3:0]       rate_sel;
  logic [TMR_W-1:0] period_cyc;
  logic [2:0]       thresh;
  logic             seq_start;
  logic             wr_en;
  logic             done_en;
  logic             any_flag;

  localparam logic [TMR_W-1:0] PERIOD_W = TMR_W'(PERIOD_CYC);

  assign wr_en   = ce && data_wr;
  assign done_en = ce && (state_r == ST_WAIT) && conv_done;
  assign cfg_view = {mask_r, sd_r, pinsel_r, 2'b00, range_r_view(), 2'b00};

  function automatic logic range_r_view();
    return range_ext_r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////
  // pointer and register writes

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ptr_r <= PTR_RESET;
    end else if (ce && ptr_wr) begin
      ptr_r <= wr_byte;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mask_r      <= CFG_RESET[CFG_MASK_BIT];
      sd_r        <= CFG_RESET[CFG_SD_BIT];
      pinsel_r    <= CFG_RESET[CFG_PINSEL_BIT];
      range_ext_r <= CFG_RESET[CFG_RANGE_BIT];
    end else if (wr_en && ptr_r == PTR_CFG_WR) begin
      // reserved bits are not stored
      mask_r      <= wr_byte[CFG_MASK_BIT];
      sd_r        <= wr_byte[CFG_SD_BIT];
      pinsel_r    <= wr_byte[CFG_PINSEL_BIT];
      range_ext_r <= wr_byte[CFG_RANGE_BIT];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rate_r <= RATE_RESET;
    end else if (wr_en && ptr_r == PTR_RATE_WR) begin
      rate_r <= wr_byte;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      chen_r   <= CHEN_RESET;
      consec_r <= CONSEC_RESET;
    end else if (wr_en && ptr_r == PTR_CHEN) begin
      chen_r <= wr_byte[1:0];
    end else if (wr_en && ptr_r == PTR_CONSEC) begin
      consec_r <= wr_byte[3:1];
    end
  end

  // a new trigger in the cycle the pending one is taken still wins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      oneshot_r <= 1'b0;
    end else if (wr_en && ptr_r == PTR_ONESHOT && sd_r) begin
      oneshot_r <= 1'b1;
    end else if (ce && seq_start) begin
      oneshot_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // register reads

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_data_r <= 8'h00;
    end else if (ce && rd_strobe) begin
      case (ptr_r)
        PTR_CFG_RD:  rd_data_r <= cfg_view;
        PTR_RATE_RD: rd_data_r <= rate_r;
        PTR_CHEN:    rd_data_r <= {6'h00, chen_r};
        PTR_CONSEC:  rd_data_r <= {4'h0, consec_r, 1'b1};
        default:     rd_data_r <= 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // conversion scheduler

  // codes above the fastest one run at the fastest rate
  assign rate_sel   = (rate_r > RATE_MAX) ? RATE_MAX[3:0] : rate_r[3:0];
  assign period_cyc = PERIOD_W >> rate_sel;
  assign seq_start  = (state_r == ST_IDLE) && ((!sd_r && tmr_r == '0) || oneshot_r);

  // period counts from sequence start, so the start-to-start spacing follows the rate
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tmr_r <= '0;
    end else if (ce) begin
      if (seq_start) begin
        tmr_r <= period_cyc - TMR_W'(1);
      end else if (tmr_r != '0) begin
        tmr_r <= tmr_r - TMR_W'(1);
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r      <= ST_IDLE;
      pend_r       <= 2'b00;
      conv_start_r <= 1'b0;
      conv_chan_r  <= 1'b0;
    end else if (ce) begin
      conv_start_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (seq_start) begin
            pend_r  <= chen_r;
            state_r <= ST_START;
          end
        end
        ST_START: begin
          if (pend_r == 2'b00) begin
            state_r <= ST_IDLE;
          end else begin
            conv_start_r <= 1'b1;
            conv_chan_r  <= !pend_r[CHEN_LOC_BIT];
            state_r      <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (conv_done) begin
            pend_r[conv_chan_r] <= 1'b0;
            state_r             <= ST_START;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
    end else if (ce) begin
      busy_r <= seq_start || (state_r != ST_IDLE && !(state_r == ST_START && pend_r == 2'b00));
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // consecutive out-of-limit qualification

  assign thresh = 3'(consec_r[0]) + 3'(consec_r[1]) + 3'(consec_r[2]) + 3'h1;

  for (genvar i = 0; i < 4; i++) begin : g_lim
    logic hit;
    logic [2:0] cnt_inc;
    assign hit     = (conv_chan_r == (i >= 2)) && ((i % 2 == 0) ? res_high : res_low);
    assign cnt_inc = (cnt_r[i] == 3'h4) ? 3'h4 : cnt_r[i] + 3'h1;
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        cnt_r[i] <= 3'h0;
        qual_r[i] <= 1'b0;
      end else if (done_en && conv_chan_r == (i >= 2)) begin
        cnt_r[i]  <= hit ? cnt_inc : 3'h0;
        qual_r[i] <= hit && (cnt_inc >= thresh);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // interrupt latch and pin

  assign any_flag = (|qual_r) || open_fault;

  // set beats acknowledge; flags keep running under the mask
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alert_latch_r <= 1'b0;
    end else if (ce) begin
      if (!pinsel_r && any_flag) begin
        alert_latch_r <= 1'b1;
      end else if (alert_ack) begin
        alert_latch_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alert_pin_o_r  <= 1'b0;
      alert_pin_oe_r <= 1'b0;
    end else if (ce) begin
      alert_pin_o_r <= 1'b0;
      if (pinsel_r) begin
        alert_pin_oe_r <= qual_r[LIM_LH] || qual_r[LIM_RH];
      end else begin
        alert_pin_oe_r <= alert_latch_r && !mask_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  // checks

  AST_CFG_READ: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && rd_strobe && ptr_r == PTR_CFG_RD) |=> rd_data_r == $past(cfg_view))
    else $error("config read view wrong");

  AST_MASKED_PIN: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && !pinsel_r && mask_r) |=> !alert_pin_oe_r)
    else $error("masked interrupt pin driven");

  AST_OVERTEMP_PIN: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && pinsel_r && (qual_r[LIM_LH] || qual_r[LIM_RH])) |=> alert_pin_oe_r)
    else $error("overtemp pin not driven");

  AST_SHUTDOWN_IDLE: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && state_r == ST_IDLE && sd_r && !oneshot_r) |=> state_r == ST_IDLE)
    else $error("conversion started in shutdown");

  AST_FINISH_SEQ: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && state_r != ST_IDLE && pend_r != 2'b00) |=> state_r != ST_IDLE)
    else $error("sequence aborted");

  AST_PERIOD_LOAD: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && seq_start) |=> tmr_r == ($past(period_cyc) - TMR_W'(1)))
    else $error("period not loaded");

  AST_CHAN_SKIP: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && state_r == ST_START && pend_r != 2'b00) |=>
      conv_start_r && (conv_chan_r ? !$past(pend_r[0]) : $past(pend_r[0])))
    else $error("disabled channel converted");

  AST_COUNT_RESTART: assert property (@(posedge clock) disable iff (!reset_n)
    (done_en && !conv_chan_r && !res_high) |=> cnt_r[LIM_LH] == 3'h0 && !qual_r[LIM_LH])
    else $error("count not restarted");

  AST_LATCH_SET: assert property (@(posedge clock) disable iff (!reset_n)
    (ce && !pinsel_r && any_flag) |=> alert_latch_r)
    else $error("latch not set");

  AST_ONESHOT_TAKE: assert property (@(posedge clock) disable iff (!reset_n)
    (wr_en && ptr_r == PTR_ONESHOT && sd_r && state_r == ST_IDLE) |=> ##[0:1] busy_r)
    else $error("one-shot not started");

  COV_ONESHOT: cover property (@(posedge clock) disable iff (!reset_n)
    sd_r && oneshot_r ##1 state_r == ST_START);
  COV_QUAL_FOUR: cover property (@(posedge clock) disable iff (!reset_n)
    thresh == 3'h4 && qual_r[LIM_LH]);
  COV_OVERTEMP_PIN: cover property (@(posedge clock) disable iff (!reset_n)
    pinsel_r && alert_pin_oe_r);

endmodule // tcc_conv_ctrl
`default_nettype wire

// >>> sim/tcc_front_model.sv
`default_nettype none
module tcc_front_model #(
  parameter int DLY = 5
) (
  // clock and converter handshake
  input  wire logic       clock,
  input  wire logic       conv_start_r,
  input  wire logic       conv_chan_r,
  output var  logic       conv_done,
  output var  logic       res_high,
  output var  logic       res_low,
  // per-channel out-of-limit selects
  input  wire logic [1:0] hi_sel,
  input  wire logic [1:0] lo_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt = 0;
  logic chan = 1'b0;
  initial begin
    conv_done = 1'b0;
    res_high  = 1'b0;
    res_low   = 1'b0;
    forever begin
      @(posedge clock);
      #1;
      // levels mean nothing outside done, so they toggle
      conv_done = 1'b0;
      res_high  = ~res_high;
      res_low   = ~res_low;
      if (cnt == 1) begin
        conv_done = 1'b1;
        res_high  = hi_sel[chan];
        res_low   = lo_sel[chan];
      end
      if (cnt != 0) begin
        cnt--;
      end
      if (conv_start_r) begin
        cnt  = DLY;
        chan = conv_chan_r;
      end
    end
  end
endmodule // tcc_front_model
`default_nettype wire

// >>> sim/test_temp_conversion_control.sv
`default_nettype none
module test_temp_conversion_control import tcc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PERIOD = 1024;
  logic       clock, reset_n, ptr_wr, data_wr, rd_strobe, open_fault, alert_ack, ce;
  logic       conv_start_r, conv_chan_r, conv_done, res_high, res_low;
  logic       alert_latch_r, busy_r, range_ext_r, pin_o, pin_oe;
  logic [1:0] hi_sel, lo_sel;
  logic [3:0] qual_r;
  logic [7:0] wr_byte, rd_data_r;
  int         miscompares, check_count, n, lim, i, k, s0, s1;
  int         starts [2];
  longint     t0, t1;

  tcc_conv_ctrl #(.PERIOD_CYC(PERIOD)) dut_u (
    .clock(clock), .reset_n(reset_n), .ce(ce),
    .ptr_wr(ptr_wr), .data_wr(data_wr), .wr_byte(wr_byte), .rd_strobe(rd_strobe),
    .rd_data_r(rd_data_r), .conv_start_r(conv_start_r), .conv_chan_r(conv_chan_r),
    .conv_done(conv_done), .res_high(res_high), .res_low(res_low),
    .open_fault(open_fault), .alert_ack(alert_ack), .qual_r(qual_r),
    .alert_latch_r(alert_latch_r), .busy_r(busy_r), .range_ext_r(range_ext_r),
    .alert_pin_o_r(pin_o), .alert_pin_oe_r(pin_oe));

  tcc_front_model front_u (
    .clock(clock), .conv_start_r(conv_start_r), .conv_chan_r(conv_chan_r),
    .conv_done(conv_done), .res_high(res_high), .res_low(res_low),
    .hi_sel(hi_sel), .lo_sel(lo_sel));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    if (conv_start_r === 1'b1) starts[conv_chan_r]++;
  end

  initial begin
    repeat (40000) @(posedge clock);
    miscompares++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int cyc);
    repeat (cyc) @(posedge clock);
    #1;
  endtask

  // pointer load, then one data write or read strobe
  task automatic access(input logic [7:0] ptr, input logic [7:0] val, input logic is_rd);
    idle(1);
    ptr_wr = 1'b1;
    wr_byte = ptr;
    idle(1);
    ptr_wr = 1'b0;
    wr_byte = val;
    data_wr = ~is_rd;
    rd_strobe = is_rd;
    idle(1);
    data_wr = 1'b0;
    rd_strobe = 1'b0;
    wr_byte = ~val;
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] val);
    access(ptr, val, 1'b0);
  endtask

  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    access(ptr, 8'h00, 1'b1);
    check(rd_data_r, exp);
  endtask

  task automatic wait_busy(input logic lvl);
    int w;
    w = 0;
    while (busy_r !== lvl && w < 3000) begin
      idle(1);
      w++;
    end
    check(busy_r, lvl);
  endtask

  task automatic seq_time(output longint t);
    wait_busy(1'b0);
    wait_busy(1'b1);
    t = $time;
  endtask

  task automatic shot();
    wr(PTR_ONESHOT, 8'h5a);
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask

  task automatic ack();
    alert_ack = 1'b1;
    idle(1);
    alert_ack = 1'b0;
  endtask

  task automatic stop_test();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, ptr_wr, data_wr, rd_strobe, open_fault, alert_ack} = '0;
    wr_byte = 8'h00;
    ce = 1'b1;
    hi_sel = 2'b00;
    lo_sel = 2'b00;
    repeat (6) @(posedge clock);
    #1;
    reset_n = 1'b1;
    rd(PTR_CFG_RD, 8'h00);
    rd(PTR_RATE_RD, 8'h08);
    rd(PTR_CHEN, 8'h03);
    rd(PTR_CONSEC, 8'h01);
    rd(8'h30, 8'h00);
    for (k = 0; k < 6; k++) begin
      wr(PTR_RATE_WR, 8'(k));
      seq_time(t0);
      seq_time(t0);
      seq_time(t1);
      check(32'((t1 - t0) / 100), PERIOD >> k);
      // two conversions of the front model take 15 cycles at any rate
      wait_busy(1'b0);
      check(32'(($time - t1) / 100), 15);
    end
    wr(PTR_RATE_WR, 8'h09);
    rd(PTR_RATE_RD, 8'h09);
    wr(PTR_RATE_WR, 8'h0c);
    rd(PTR_RATE_RD, 8'h0c);
    wr(PTR_RATE_WR, 8'h05);
    // shutdown, then single triggered cycles
    wr(PTR_CFG_WR, 8'h40);
    wait_busy(1'b0);
    s0 = starts[0] + starts[1];
    check(32'(s0 % 2), 0);
    idle(100);
    check(starts[0] + starts[1], s0);
    shot();
    check(starts[0] + starts[1], s0 + 2);
    idle(100);
    check(starts[0] + starts[1], s0 + 2);
    wr(PTR_CHEN, 8'h02);
    rd(PTR_CHEN, 8'h02);
    s0 = starts[0];
    s1 = starts[1];
    shot();
    check(starts[0], s0);
    check(starts[1], s1 + 1);
    wr(PTR_CHEN, 8'h03);
    // consecutive out-of-limit qualification, high then low
    for (n = 1; n <= 4; n++) begin
      for (lim = 0; lim < 2; lim++) begin
        wr(PTR_CONSEC, 8'((1 << n) - 1));
        rd(PTR_CONSEC, 8'((1 << n) - 1));
        hi_sel = {1'b0, lim == 0};
        lo_sel = {1'b0, lim == 1};
        for (i = 1; i <= n; i++) begin
          shot();
          idle(2);
          check(qual_r[lim], i == n);
          check(pin_oe, i == n);
        end
        hi_sel = 2'b00;
        lo_sel = 2'b00;
        shot();
        check(qual_r, 4'h0);
        ack();
      end
    end
    wr(PTR_CONSEC, 8'h01);
    hi_sel = 2'b01;
    wr(PTR_CFG_WR, 8'hc0);
    shot();
    idle(2);
    check(qual_r[0], 1'b1);
    check(alert_latch_r, 1'b1);
    check(pin_oe, 1'b0);
    wr(PTR_CFG_WR, 8'he0);
    idle(2);
    check(pin_oe, 1'b1);
    hi_sel = 2'b00;
    lo_sel = 2'b01;
    shot();
    idle(2);
    check(qual_r, 4'h2);
    check(pin_oe, 1'b0);
    lo_sel = 2'b00;
    wr(PTR_CFG_WR, 8'h44);
    shot();
    ack();
    idle(2);
    check(range_ext_r, 1'b1);
    rd(PTR_CFG_RD, 8'h44);
    check(pin_oe, 1'b0);
    open_fault = 1'b1;
    idle(3);
    check(pin_oe, 1'b1);
    check(pin_o, 1'b0);
    open_fault = 1'b0;
    // a write with the clock enable low must not land
    ce = 1'b0;
    wr(PTR_CHEN, 8'h01);
    ce = 1'b1;
    rd(PTR_CHEN, 8'h03);
    wr(PTR_CFG_WR, 8'h00);
    wait_busy(1'b1);
    stop_test();
  end
endmodule // test_temp_conversion_control
`default_nettype wire
